// ---- hdl/cthd_pkg.sv ----
// cthd_pkg: constants shared by the current distortion calculator
// assumes a single 20 MHz system clock
package cthd_pkg;
    localparam int          NUM_CH        = 5;     // phase a,b,c, residual first, second
    localparam int          MAG_W         = 16;
    localparam int          ORD_W         = 5;
    localparam int          RES_W         = 24;
    localparam int          THR_W         = 14;
    localparam int          ACC_W         = 37;    // 30 squares of 16-bit magnitudes
    localparam logic [4:0]  ORD_FUND      = 5'h01;
    localparam logic [4:0]  ORD_LAST_HARM = 5'h1F;  // 31st component
    localparam logic [2:0]  CH_PH_A       = 3'h0;
    localparam logic [2:0]  CH_PH_B       = 3'h1;
    localparam logic [2:0]  CH_PH_C       = 3'h2;
    localparam logic [2:0]  CH_RES_1      = 3'h3;
    localparam logic [2:0]  CH_RES_2      = 3'h4;
    // results and thresholds are in 0.01 % units
    localparam logic [63:0] SCALE_POWER   = 64'h0000_0000_0000_2710;  // 10000
    localparam logic [63:0] SCALE_AMPL    = 64'h0000_0000_05F5_E100;  // 10000 squared
    localparam logic [13:0] THR_MIN       = 14'h000A;  // 0.10 %
    localparam logic [13:0] THR_MAX       = 14'h2710;  // 100.00 %
    localparam logic [13:0] THR_DEFAULT   = 14'h03E8;  // 10.00 %
    localparam int          RESET_PCT     = 97;
    localparam int          DIV_STEPS     = 64;
    localparam int          ROOT_STEPS    = 16;
    localparam logic        MODE_AMPL     = 1'b0;      // default method
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          REFRESH_NS    = 5_000_000;  // 5 ms time base
    localparam int          REFRESH_CYC   = REFRESH_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_ROOT, ST_DONE} cthd_state_e;
endpackage : cthd_pkg

// ---- hdl/cthd_calc.sv ----
// cthd_calc: per-channel harmonic distortion with threshold pick-up
// assumes magnitudes arrive one component per cycle, synchronous to clk
`timescale 1ns/1ps
module cthd_calc #(
    parameter int STALE_CYC = 2 * cthd_pkg::REFRESH_CYC
) (
    input  wire logic                                        clk,
    input  wire logic                                        rst_n,
    input  wire logic                                        cfg_power_mode,
    input  wire logic                                        mag_valid,
    input  wire logic [2:0]                                  mag_chan,
    input  wire logic [cthd_pkg::ORD_W-1:0]                  mag_order,
    input  wire logic [cthd_pkg::MAG_W-1:0]                  mag_value,
    input  wire logic                                        mag_last,
    input  wire logic [cthd_pkg::NUM_CH-1:0][cthd_pkg::THR_W-1:0] thr_in,
    output logic                                             power_mode_q,
    output logic [cthd_pkg::NUM_CH-1:0][cthd_pkg::RES_W-1:0] result_q,
    output logic [cthd_pkg::NUM_CH-1:0]                      result_valid_q,
    output logic [cthd_pkg::NUM_CH-1:0]                      pickup_q,
    output logic [cthd_pkg::NUM_CH-1:0]                      stale_q
);
    localparam int ACC_W = cthd_pkg::ACC_W;

    function automatic logic [2:0] first_pend(input logic [cthd_pkg::NUM_CH-1:0] p);
        first_pend = 3'h0;
        for (int i = cthd_pkg::NUM_CH - 1; i >= 0; i--)
            if (p[i])
                first_pend = 3'(i);
    endfunction : first_pend

    logic                                      mode_loaded_q;
    logic [cthd_pkg::NUM_CH-1:0][ACC_W-1:0]    harm_acc_q;
    logic [cthd_pkg::NUM_CH-1:0][31:0]         fund_acc_q;
    logic [cthd_pkg::NUM_CH-1:0][ACC_W-1:0]    harm_lat_q;
    logic [cthd_pkg::NUM_CH-1:0][31:0]         fund_lat_q;
    logic [cthd_pkg::NUM_CH-1:0]               pend_q;
    logic [cthd_pkg::NUM_CH-1:0][cthd_pkg::THR_W-1:0] thr_q;
    cthd_pkg::cthd_state_e                     st_q;
    logic [2:0]                                cur_q;
    logic [31:0]                               den_q;
    logic [63:0]                               num_q;
    logic [63:0]                               quot_q;
    logic [32:0]                               rem_q;
    logic [5:0]                                cnt_q;
    logic [31:0]                               op_q;
    logic [31:0]                               root_q;
    logic [31:0]                               bit_q;
    logic [31:0]                               sq;
    logic [32:0]                               rem_sh;
    logic [31:0]                               quot_sat;
    logic [31:0]                               trial;
    logic [cthd_pkg::RES_W-1:0]                r_new;
    logic                                      in_ok;

    assign sq       = 32'(mag_value) * 32'(mag_value);
    assign in_ok    = mag_valid && (mag_chan < 3'(cthd_pkg::NUM_CH));
    assign rem_sh   = {rem_q[31:0], num_q[63]};
    assign quot_sat = (|quot_q[63:32]) ? 32'hFFFF_FFFF : quot_q[31:0];
    assign trial    = root_q + bit_q;

    // method latched once after reset; setting-group changes cannot reach it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_mode_q  <= cthd_pkg::MODE_AMPL;
            mode_loaded_q <= 1'b0;
        end
        else if (!mode_loaded_q)
        begin
            power_mode_q  <= cfg_power_mode;
            mode_loaded_q <= 1'b1;
        end
    end

    generate
        for (genvar c = 0; c < cthd_pkg::NUM_CH; c++)
        begin : g_ch
            logic        hit;
            logic [17:0] age_q;
            assign hit = in_ok && (mag_chan == 3'(c));

            // accumulate one component per cycle; the DC bin is ignored
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    harm_acc_q[c] <= '0;
                    fund_acc_q[c] <= '0;
                    harm_lat_q[c] <= '0;
                    fund_lat_q[c] <= '0;
                end
                else if (hit)
                begin
                    logic [ACC_W-1:0] h;
                    logic [31:0]      f;
                    h = harm_acc_q[c];
                    f = fund_acc_q[c];
                    if (mag_order >= 5'h02 && mag_order <= cthd_pkg::ORD_LAST_HARM)
                        h = h + ACC_W'(sq);
                    if (mag_order == cthd_pkg::ORD_FUND)
                        f = sq;
                    if (mag_last)
                    begin
                        harm_lat_q[c] <= h;
                        fund_lat_q[c] <= f;
                        harm_acc_q[c] <= '0;
                        fund_acc_q[c] <= '0;
                    end
                    else
                    begin
                        harm_acc_q[c] <= h;
                        fund_acc_q[c] <= f;
                    end
                end
            end

            // a refresh landing as the channel is taken is kept: set wins
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    pend_q[c] <= 1'b0;
                else if (hit && mag_last)
                    pend_q[c] <= 1'b1;
                else if (st_q == cthd_pkg::ST_IDLE && pend_q != '0
                         && first_pend(pend_q) == 3'(c))
                    pend_q[c] <= 1'b0;
            end

            // out-of-range limits fall back to the default
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    thr_q[c] <= cthd_pkg::THR_DEFAULT;
                else if (thr_in[c] < cthd_pkg::THR_MIN || thr_in[c] > cthd_pkg::THR_MAX)
                    thr_q[c] <= cthd_pkg::THR_DEFAULT;
                else
                    thr_q[c] <= thr_in[c];
            end

            // stale flag after two missed refresh periods
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    age_q      <= '0;
                    stale_q[c] <= 1'b0;
                end
                else if (hit && mag_last)
                begin
                    age_q      <= '0;
                    stale_q[c] <= 1'b0;
                end
                else if (age_q >= 18'(STALE_CYC))
                    stale_q[c] <= 1'b1;
                else
                    age_q <= age_q + 18'h00001;
            end

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    result_q[c]       <= '0;
                    result_valid_q[c] <= 1'b0;
                    pickup_q[c]       <= 1'b0;
                end
                else if (st_q == cthd_pkg::ST_DONE && cur_q == 3'(c))
                begin
                    result_q[c]       <= r_new;
                    result_valid_q[c] <= 1'b1;
                    if (32'(r_new) > 32'(thr_q[c]))
                        pickup_q[c] <= 1'b1;
                    else if (32'(r_new) * 32'd100 < 32'(thr_q[c]) * 32'(cthd_pkg::RESET_PCT))
                        pickup_q[c] <= 1'b0;
                end
                else
                    result_valid_q[c] <= 1'b0;
            end

            p_pick_set: assert property (@(posedge clk) disable iff (!rst_n)
                result_valid_q[c] && 32'(result_q[c]) > 32'($past(thr_q[c])) |-> pickup_q[c])
                else $error("pick-up missing above threshold");
            p_pick_clr: assert property (@(posedge clk) disable iff (!rst_n)
                result_valid_q[c] && 32'(result_q[c]) * 32'd100 < 32'($past(thr_q[c])) * 32'd97
                |-> !pickup_q[c])
                else $error("pick-up held below release level");
            p_pick_hold: assert property (@(posedge clk) disable iff (!rst_n)
                !result_valid_q[c] |-> $stable(pickup_q[c]))
                else $error("pick-up changed without a new result");
            p_refresh: assert property (@(posedge clk) disable iff (!rst_n)
                hit && mag_last |-> ##[1:600] result_valid_q[c])
                else $error("refresh not recomputed in time");
            p_thr_rng: assert property (@(posedge clk) disable iff (!rst_n)
                thr_q[c] >= 14'h000A && thr_q[c] <= 14'h2710)
                else $error("threshold out of range");
        end
    endgenerate

    // one shared divider and root engine; five channels fit easily in 5 ms
    always_comb
    begin
        if (den_q == 32'h0000_0000)
            r_new = '0;
        else if (power_mode_q)
            r_new = (|quot_sat[31:24]) ? 24'hFFFFFF : quot_sat[23:0];
        else
            r_new = root_q[23:0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q   <= cthd_pkg::ST_IDLE;
            cur_q  <= '0;
            den_q  <= '0;
            num_q  <= '0;
            quot_q <= '0;
            rem_q  <= '0;
            cnt_q  <= '0;
            op_q   <= '0;
            root_q <= '0;
            bit_q  <= '0;
        end
        else
        begin
            case (st_q)
                cthd_pkg::ST_IDLE:
                    if (pend_q != '0)
                    begin
                        cur_q  <= first_pend(pend_q);
                        den_q  <= fund_lat_q[first_pend(pend_q)];
                        num_q  <= 64'(harm_lat_q[first_pend(pend_q)]) *
                                  (power_mode_q ? cthd_pkg::SCALE_POWER : cthd_pkg::SCALE_AMPL);
                        quot_q <= '0;
                        rem_q  <= '0;
                        cnt_q  <= '0;
                        root_q <= '0;
                        st_q   <= (fund_lat_q[first_pend(pend_q)] == 32'h0)
                                  ? cthd_pkg::ST_DONE : cthd_pkg::ST_DIV;
                    end
                cthd_pkg::ST_DIV:
                begin
                    num_q <= {num_q[62:0], 1'b0};
                    if (rem_sh >= {1'b0, den_q})
                    begin
                        rem_q  <= rem_sh - {1'b0, den_q};
                        quot_q <= {quot_q[62:0], 1'b1};
                    end
                    else
                    begin
                        rem_q  <= rem_sh;
                        quot_q <= {quot_q[62:0], 1'b0};
                    end
                    if (cnt_q == 6'(cthd_pkg::DIV_STEPS - 1))
                    begin
                        cnt_q <= '0;
                        st_q  <= power_mode_q ? cthd_pkg::ST_DONE : cthd_pkg::ST_ROOT;
                        bit_q <= 32'h4000_0000;
                        op_q  <= (|quot_q[62:31]) ? 32'hFFFF_FFFF
                                 : {quot_q[30:0], (rem_sh >= {1'b0, den_q})};
                    end
                    else
                        cnt_q <= cnt_q + 6'h01;
                end
                cthd_pkg::ST_ROOT:
                begin
                    // bitwise integer square root, one result bit per op bit pair
                    if (op_q >= trial)
                    begin
                        op_q   <= op_q - trial;
                        root_q <= (root_q >> 1) + bit_q;
                    end
                    else
                        root_q <= root_q >> 1;
                    bit_q <= bit_q >> 2;
                    if (cnt_q == 6'(cthd_pkg::ROOT_STEPS - 1))
                        st_q <= cthd_pkg::ST_DONE;
                    cnt_q <= cnt_q + 6'h01;
                end
                cthd_pkg::ST_DONE:
                    st_q <= cthd_pkg::ST_IDLE;
                default:
                    st_q <= cthd_pkg::ST_IDLE;
            endcase
        end
    end

    p_mode_def: assert property (@(posedge clk) disable iff (!rst_n)
        !mode_loaded_q |-> power_mode_q == 1'b0)
        else $error("method not amplitude before load");
    p_mode_static: assert property (@(posedge clk) disable iff (!rst_n)
        mode_loaded_q |=> $stable(power_mode_q))
        else $error("method changed after load");
    p_zero_fund: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == cthd_pkg::ST_DONE && den_q == 32'h0 |=> result_q[cur_q] == '0)
        else $error("zero fundamental gave nonzero result");
    p_power_res: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == cthd_pkg::ST_DONE && power_mode_q && den_q != 32'h0 && quot_q[63:24] == '0
        |=> 64'(result_q[cur_q]) == $past(quot_q))
        else $error("power ratio result wrong");
    p_root_res: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == cthd_pkg::ST_DONE && !power_mode_q && den_q != 32'h0
        |-> 64'(root_q) * 64'(root_q) <= 64'(quot_sat)
            && (64'(root_q) + 64'h1) * (64'(root_q) + 64'h1) > 64'(quot_sat))
        else $error("amplitude root out of bounds");
endmodule : cthd_calc

// ---- verif/cthd_src_model.sv ----
// cthd_src_model: upstream spectral stage feeding one magnitude set at a time
// assumes the caller runs send from a single process, synchronous to clk
`timescale 1ns/1ps
module cthd_src_model (
    input  wire logic        clk,
    output logic             mag_valid,
    output logic [2:0]       mag_chan,
    output logic [4:0]       mag_order,
    output logic [15:0]      mag_value,
    output logic             mag_last
);
    initial
    begin
        mag_valid = 1'b0;
        mag_chan  = 3'h0;
        mag_order = 5'h00;
        mag_value = 16'h0000;
        mag_last  = 1'b0;
    end

    // idle cycles show inverted data so a stale value never looks valid
    task automatic send(input logic [2:0] ch, input logic [31:0][15:0] m, input int gap);
        for (int k = 0; k < 32; k++)
        begin
            @(posedge clk);
            mag_valid <= 1'b1;
            mag_chan  <= ch;
            mag_order <= 5'(k);
            mag_value <= m[k];
            mag_last  <= (k == 31);
            repeat (gap)
            begin
                @(posedge clk);
                mag_valid <= 1'b0;
                mag_last  <= 1'b0;
                mag_value <= ~m[k];
            end
        end
        @(posedge clk);
        mag_valid <= 1'b0;
        mag_last  <= 1'b0;
        mag_value <= ~m[31];
    endtask : send
endmodule : cthd_src_model

// ---- verif/tb_top.sv ----
// tb_top: random and corner magnitude sets through cthd_calc, both methods
// assumes the design behind the hand-over latencies; run stays under 60000 cycles
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    logic                                             clk;
    logic                                             rst_n;
    logic                                             cfg_power_mode;
    logic                                             mag_valid;
    logic [2:0]                                       mag_chan;
    logic [cthd_pkg::ORD_W-1:0]                       mag_order;
    logic [cthd_pkg::MAG_W-1:0]                       mag_value;
    logic                                             mag_last;
    logic [cthd_pkg::NUM_CH-1:0][cthd_pkg::THR_W-1:0] thr_in;
    logic                                             power_mode_q;
    logic [cthd_pkg::NUM_CH-1:0][cthd_pkg::RES_W-1:0] result_q;
    logic [cthd_pkg::NUM_CH-1:0]                      result_valid_q;
    logic [cthd_pkg::NUM_CH-1:0]                      pickup_q;
    logic [cthd_pkg::NUM_CH-1:0]                      stale_q;
    logic [cthd_pkg::NUM_CH-1:0]                      exp_pk;
    logic                                             mode;
    int                                               num_errors;
    int                                               tests_run;
    int                                               hv [5] = '{101, 98, 96, 100, 101};

    cthd_calc #(.STALE_CYC(200)) i_cthd_calc (.clk(clk), .rst_n(rst_n),
        .cfg_power_mode(cfg_power_mode), .mag_valid(mag_valid), .mag_chan(mag_chan),
        .mag_order(mag_order), .mag_value(mag_value), .mag_last(mag_last), .thr_in(thr_in),
        .power_mode_q(power_mode_q), .result_q(result_q), .result_valid_q(result_valid_q),
        .pickup_q(pickup_q), .stale_q(stale_q));
    cthd_src_model i_cthd_src_model (.clk(clk), .mag_valid(mag_valid), .mag_chan(mag_chan),
        .mag_order(mag_order), .mag_value(mag_value), .mag_last(mag_last));

    function automatic longint unsigned isqrt(input longint unsigned v);
        longint unsigned r;
        longint unsigned b;
        r = 0;
        b = 64'h4000_0000_0000_0000;
        while (b > v) b >>= 2;
        while (b != 0)
        begin
            if (v >= r + b)
            begin
                v -= r + b;
                r = (r >> 1) + b;
            end
            else r >>= 1;
            b >>= 2;
        end
        return r;
    endfunction : isqrt

    function automatic logic [23:0] exp_res(input logic [31:0][15:0] m, input logic pm);
        longint unsigned s;
        longint unsigned x;
        longint unsigned f2;
        s = 0;
        for (int k = 2; k < 32; k++)
        begin
            x = m[k];
            s += x * x;
        end
        x = m[1];
        f2 = x * x;
        if (f2 == 0) return 24'h000000;
        x = pm ? s * 10000 / f2 : isqrt(s * 100000000 / f2);
        return (x > 64'hFF_FFFF) ? 24'hFFFFFF : x[23:0];
    endfunction : exp_res

    function automatic int eff_thr(input logic [13:0] t);
        return (t < cthd_pkg::THR_MIN || t > cthd_pkg::THR_MAX)
               ? int'(cthd_pkg::THR_DEFAULT) : int'(t);
    endfunction : eff_thr

    function automatic logic [31:0][15:0] rnd_set(input logic [15:0] f);
        logic [31:0][15:0] m;
        m[0] = 16'($urandom);
        m[1] = f;
        for (int k = 2; k < 32; k++) m[k] = 16'($urandom % 256);
        return m;
    endfunction : rnd_set

    task automatic run_set(input logic [2:0] ch, input logic [31:0][15:0] m);
        logic [23:0] e;
        int          t;
        int          n;
        e = exp_res(m, mode);
        t = eff_thr(thr_in[ch]);
        i_cthd_src_model.send(ch, m, $urandom % 3);
        n = 0;
        while (n < 200 && result_valid_q[ch] !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(result_valid_q[ch], 1'b1);
        `CHK(stale_q[ch], 1'b0);
        `CHK(result_q[ch], e);
        if (int'(e) > t) exp_pk[ch] = 1'b1;
        else if (int'(e) * 100 < t * 97) exp_pk[ch] = 1'b0;
        `CHK(pickup_q, exp_pk);
        @(posedge clk);
        #1;
        `CHK(result_valid_q[ch], 1'b0);
    endtask : run_set

    task automatic do_reset(input logic pm);
        @(posedge clk);
        rst_n <= 1'b0;
        cfg_power_mode <= pm;
        repeat (10) @(posedge clk);
        `CHK(pickup_q, 5'h00);
        rst_n <= 1'b1;
        exp_pk = 5'h00;
        mode = pm;
        repeat (2) @(posedge clk);
        cfg_power_mode <= ~pm;
        #1;
        `CHK(power_mode_q, pm);
        `CHK(stale_q, 5'h00);
    endtask : do_reset

    task automatic report_and_stop;
        $display("errors=%0d comparisons=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        int n;
        rst_n = 1'b0;
        cfg_power_mode = 1'b0;
        thr_in = '0;
        num_errors = 0;
        tests_run = 0;
        void'($urandom(99));
        for (int p = 0; p < 2; p++)
        begin
            do_reset(p[0]);
            // out-of-range limit on channel 0 falls back to the default
            thr_in[0] <= 14'h0000;
            for (int c = 1; c < 5; c++) thr_in[c] <= 14'($urandom % 2000 + 10);
            for (int i = 0; i < 12; i++) run_set(3'($urandom % 5), rnd_set(16'($urandom % 64000 + 1000)));
            run_set(3'h2, rnd_set(16'h0000));
            if (p == 0)
                for (int i = 0; i < 5; i++)
                begin
                    logic [31:0][15:0] m;
                    m = '0;
                    m[1] = 16'h03E8;
                    m[2] = 16'(hv[i]);
                    run_set(3'h0, m);
                end
        end
        // a set on an unused channel number must leave every result untouched
        i_cthd_src_model.send(3'h5, rnd_set(16'h1000), 0);
        n = 0;
        repeat (150)
        begin
            @(posedge clk);
            #1;
            if (result_valid_q !== 5'h00) n++;
        end
        `CHK(n, 0);
        // no set for longer than the stale span flags every channel
        repeat (210) @(posedge clk);
        #1;
        `CHK(stale_q, 5'h1F);
        report_and_stop();
    end
endmodule : tb_top
